// >>> design/cal_ctrl_defines.svh
`ifndef CAL_CTRL_DEFINES_SVH
`define CAL_CTRL_DEFINES_SVH

`define IDX_CAL_CONFIG     10'h062
`define IDX_CAL_STATUS     10'h06a
`define IDX_CAL_PIN_CFG    10'h06b
`define IDX_CALIBRATION_SOFTWARE_TRIGGER  10'h06c
`define IDX_CAL_LOW_POWER  10'h06e

`define RST_CAL_CONFIG     8'h01
`define RST_CAL_PIN_CFG    8'h00
`define RST_CALIBRATION_SOFTWARE_TRIGGER  8'h01
`define RST_CAL_LOW_POWER  8'h88

`define POS_FG_RUN         0
`define POS_BG_EN          1
`define POS_FOREGROUND_COMPLETE_FLAG        0
`define POS_BG_STOPPED     1
`define POS_STAT_LO        2
`define POS_STAT_SEL_LO    1
`define POS_TRIG_SRC       0
`define POS_SOFT_TRIG      0
`define POS_LOW_POWER_CALIBRATION_ENABLE          0
`define POS_TRIGGER_CONTROLLED_SLEEP        1
`define POS_WAKE_LO        3
`define POS_SLEEP_LO       5

`define DLY_CODE0_CYCLES   41'd1152
`define DLY_TAIL_CYCLES    41'd128
`define DLY_EXP_STEP       3
`define SLEEP_EXP_BASE     19
`define WAKE_EXP_BASE      22

`endif

// >>> design/cal_ctrl_pkg.sv
package cal_ctrl_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic       fg_finished;
    logic       bg_halted;
    logic       core_cal_done;
    logic       alarm;
    logic [2:0] stat_code;
  } engine_evt_t;

  typedef struct packed {
    logic values_reset;
    logic fg_start;
    logic bg_run;
    logic bg_stop_req;
    logic core_sleep;
    logic core_cal_req;
  } engine_ctl_t;

  typedef enum logic [3:0] {
    ST_RESET_VALS, ST_FG, ST_BG_RUN, ST_BG_HALT, ST_BG_STOPPED,
    ST_LP_SLEEP, ST_LP_WAKE, ST_LP_CAL, ST_DONE
  } cal_state_t;
endpackage : cal_ctrl_pkg

// >>> design/level_sync.sv
`timescale 1ns/100ps
module level_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;

  // Stage one feeds only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : level_sync

// >>> design/delay_timer.sv
`timescale 1ns/100ps
module delay_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [40:0] cycles,
  input  wire logic        abort,
  output logic             done
);
  logic [40:0] count_q;
  logic        run_q;

  wire logic last = run_q && (count_q == 41'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 41'd0;
      run_q   <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= last && !load && !abort;
      if (load) begin
        count_q <= cycles;
        run_q   <= 1'b1;
      end else if (abort || last) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        count_q <= count_q - 41'd1;
      end
    end
  end
endmodule : delay_timer

// >>> design/cal_ctrl.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`include "cal_ctrl_defines.svh"
module cal_ctrl #(
  parameter int unsigned SLEEP_EXP_BASE = `SLEEP_EXP_BASE,
  parameter int unsigned WAKE_EXP_BASE  = `WAKE_EXP_BASE
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire cal_ctrl_pkg::apb_req_t    apb_req,
  output cal_ctrl_pkg::apb_rsp_t         apb_rsp,
  input  wire logic                      hardware_trigger_pin,
  output logic                           status_output_pin,
  input  wire cal_ctrl_pkg::engine_evt_t engine_evt,
  output cal_ctrl_pkg::engine_ctl_t      engine_ctl
);
  import cal_ctrl_pkg::*;

  function automatic logic [11:0] byte_addr(input logic [9:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

  // Code 0 is a fixed short delay; others grow by a factor of eight per step
  function automatic logic [40:0] delay_cycles(input logic [2:0] code,
                                               input int unsigned base_exp);
    int unsigned sh;
    sh = base_exp + `DLY_EXP_STEP * int'(code);
    if (code == 3'd0) begin
      delay_cycles = `DLY_CODE0_CYCLES;
    end else begin
      delay_cycles = (41'd1 << sh[5:0]) + `DLY_TAIL_CYCLES;
    end
  endfunction : delay_cycles

  logic [7:0]  config_q;
  logic [7:0]  pin_cfg_q;
  logic [7:0]  soft_trig_q;
  logic [7:0]  low_power_q;
  logic        foreground_complete_flag_q;
  logic        stopped_q;
  logic        hw_trig_sync;
  logic        timer_done;
  cal_state_t  state_q;
  cal_state_t  state_d;

  // Register bus decode
  wire logic setup   = apb_req.psel && !apb_req.penable && !apb_rsp.pready;
  wire logic access  = apb_req.psel && apb_req.penable && apb_rsp.pready;
  wire logic wr_en   = access && apb_req.pwrite;
  wire logic hit_cfg = apb_req.paddr == byte_addr(`IDX_CAL_CONFIG);
  wire logic hit_sts = apb_req.paddr == byte_addr(`IDX_CAL_STATUS);
  wire logic hit_pin = apb_req.paddr == byte_addr(`IDX_CAL_PIN_CFG);
  wire logic hit_sft = apb_req.paddr == byte_addr(`IDX_CALIBRATION_SOFTWARE_TRIGGER);
  wire logic hit_lp  = apb_req.paddr == byte_addr(`IDX_CAL_LOW_POWER);
  wire logic mapped  = hit_cfg || hit_sts || hit_pin || hit_sft || hit_lp;
  wire logic wr_cfg  = wr_en && hit_cfg;

  wire logic [7:0] status_word = {3'b000, engine_evt.stat_code,
                                  stopped_q, foreground_complete_flag_q};

  wire logic [7:0] rd_data = hit_cfg ? config_q    :
                             hit_sts ? status_word :
                             hit_pin ? pin_cfg_q   :
                             hit_sft ? soft_trig_q :
                             hit_lp  ? low_power_q : 8'h00;

  // Field views
  wire logic       fg_run    = config_q[`POS_FG_RUN];
  wire logic       bg_en     = config_q[`POS_BG_EN];
  wire logic [1:0] stat_sel  = pin_cfg_q[`POS_STAT_SEL_LO +: 2];
  wire logic       trig_src  = pin_cfg_q[`POS_TRIG_SRC];
  wire logic       soft_trig = soft_trig_q[`POS_SOFT_TRIG];
  wire logic       low_power_calibration_enable     = low_power_q[`POS_LOW_POWER_CALIBRATION_ENABLE];
  wire logic       trigger_controlled_sleep   = low_power_q[`POS_TRIGGER_CONTROLLED_SLEEP];
  wire logic [1:0] wake_code = low_power_q[`POS_WAKE_LO +: 2];
  wire logic [2:0] slp_code  = low_power_q[`POS_SLEEP_LO +: 3];

  // Pin never reaches the trigger while the soft source is chosen
  wire logic cal_trigger = trig_src ? hw_trig_sync : soft_trig;

  wire logic lp_active  = low_power_calibration_enable && bg_en;
  wire cal_state_t bg_entry = lp_active ? ST_LP_SLEEP : ST_BG_RUN;

  wire logic status_pin_d = (stat_sel == 2'd0) ? foreground_complete_flag_q         :
                            (stat_sel == 2'd1) ? stopped_q         :
                            (stat_sel == 2'd2) ? engine_evt.alarm  : 1'b0;

  level_sync u_trig_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (hardware_trigger_pin),
    .sync_out (hw_trig_sync)
  );

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q    <= `RST_CAL_CONFIG;
      pin_cfg_q   <= `RST_CAL_PIN_CFG;
      soft_trig_q <= `RST_CALIBRATION_SOFTWARE_TRIGGER;
      low_power_q <= `RST_CAL_LOW_POWER;
    end else if (wr_en) begin
      if (hit_cfg) config_q    <= {6'h00, apb_req.pwdata[1:0]};
      if (hit_pin) pin_cfg_q   <= {5'h00, apb_req.pwdata[2:0]};
      if (hit_sft) soft_trig_q <= {7'h00, apb_req.pwdata[0]};
      if (hit_lp)  low_power_q <= {apb_req.pwdata[7:3], 1'b0, apb_req.pwdata[1:0]};
    end
  end

  // No wait state: ready comes in the first access cycle, and every answer signal is on a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready  <= setup;
      apb_rsp.pslverr <= setup && !mapped;
      if (setup) begin
        apb_rsp.prdata <= {24'h000000, (apb_req.pwrite ? 8'h00 : rd_data)};
      end
    end
  end

  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET_VALS: begin
        if (fg_run) state_d = ST_FG;
        else if (bg_en) state_d = bg_entry;
        else state_d = ST_DONE;
      end
      ST_FG: begin
        if (engine_evt.fg_finished) state_d = bg_en ? bg_entry : ST_DONE;
      end
      ST_BG_RUN: begin
        if (!bg_en) state_d = ST_DONE;
        else if (lp_active) state_d = ST_LP_SLEEP;
        else if (!cal_trigger) state_d = ST_BG_HALT;
      end
      ST_BG_HALT: begin
        if (!bg_en) state_d = ST_DONE;
        else if (engine_evt.bg_halted) state_d = ST_BG_STOPPED;
        else if (cal_trigger) state_d = ST_BG_RUN;
      end
      ST_BG_STOPPED: begin
        if (!bg_en) state_d = ST_DONE;
        else if (cal_trigger) state_d = bg_entry;
      end
      ST_LP_SLEEP: begin
        if (!lp_active) state_d = bg_en ? ST_BG_RUN : ST_DONE;
        else if (trigger_controlled_sleep && !cal_trigger) state_d = ST_LP_WAKE;
        else if (!trigger_controlled_sleep && timer_done) state_d = ST_LP_WAKE;
      end
      ST_LP_WAKE: begin
        if (!lp_active) state_d = bg_en ? ST_BG_RUN : ST_DONE;
        else if (timer_done) state_d = ST_LP_CAL;
      end
      ST_LP_CAL: begin
        // Never pass through background run once background is off
        if (engine_evt.core_cal_done) state_d = bg_en ? bg_entry : ST_DONE;
      end
      ST_DONE: begin
        if (bg_en) state_d = bg_entry;
      end
      default: state_d = ST_RESET_VALS;
    endcase
    if (wr_cfg) state_d = ST_RESET_VALS;
  end

  // Timer loads on entering a timed phase; trigger-held sleep needs no count
  wire logic enter_sleep = state_d == ST_LP_SLEEP && state_q != ST_LP_SLEEP;
  wire logic enter_wake  = state_d == ST_LP_WAKE && state_q != ST_LP_WAKE;
  wire logic timer_load  = (enter_sleep && !trigger_controlled_sleep) || enter_wake;
  wire logic timer_abort = state_d != ST_LP_SLEEP && state_d != ST_LP_WAKE;
  wire logic [40:0] timer_cycles = enter_wake ?
                                   delay_cycles({1'b0, wake_code}, WAKE_EXP_BASE) :
                                   delay_cycles(slp_code, SLEEP_EXP_BASE);

  delay_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (timer_load),
    .cycles  (timer_cycles),
    .abort   (timer_abort),
    .done    (timer_done)
  );

  // Flag causes; a set in the same cycle as a restart wins
  wire logic fg_set   = (state_q == ST_RESET_VALS && !fg_run && !wr_cfg) ||
                        (state_q == ST_FG && engine_evt.fg_finished);
  wire logic stop_set = (state_q == ST_BG_HALT && engine_evt.bg_halted) ||
                        (state_d == ST_DONE && state_q != ST_DONE);
  wire logic stop_clr = (state_q == ST_BG_STOPPED && state_d != ST_BG_STOPPED) ||
                        (state_q == ST_DONE && state_d != ST_DONE) || wr_cfg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_RESET_VALS;
      foreground_complete_flag_q <= 1'b0;
      stopped_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (fg_set) foreground_complete_flag_q <= 1'b1;
      else if (wr_cfg) foreground_complete_flag_q <= 1'b0;
      if (stop_set) stopped_q <= 1'b1;
      else if (stop_clr) stopped_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      engine_ctl        <= '0;
      status_output_pin <= 1'b0;
    end else begin
      status_output_pin       <= status_pin_d;
      engine_ctl.values_reset <= state_d == ST_RESET_VALS;
      engine_ctl.fg_start     <= state_d == ST_FG;
      engine_ctl.bg_run       <= state_d == ST_BG_RUN;
      engine_ctl.bg_stop_req  <= state_d == ST_BG_HALT;
      engine_ctl.core_sleep   <= state_d == ST_LP_SLEEP;
      engine_ctl.core_cal_req <= state_d == ST_LP_CAL;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_status_pin_mux: assert property (##1 status_output_pin == $past(status_pin_d))
    else $error("status pin does not follow selected source");
  a_soft_source: assert property ((state_q == ST_BG_RUN && bg_en && !lp_active && !trig_src
                                   && soft_trig && !hw_trig_sync && !wr_cfg)
                                  |=> state_q == ST_BG_RUN)
    else $error("soft trigger source not honoured");
  a_pin_source: assert property ((state_q == ST_BG_RUN && bg_en && !lp_active && trig_src
                                  && !hw_trig_sync && !wr_cfg)
                                 |=> state_q == ST_BG_HALT)
    else $error("pin trigger source not honoured");
  a_cfg_restart: assert property (wr_cfg |=> state_q == ST_RESET_VALS
                                  && engine_ctl.values_reset)
    else $error("config write did not reset values");
  a_fg_skip_done: assert property ((state_q == ST_RESET_VALS && !fg_run && !wr_cfg)
                                   |=> foreground_complete_flag_q && state_q != ST_FG)
    else $error("skipped foreground not flagged done");
  a_halt_sets_flag: assert property ((state_q == ST_BG_HALT && engine_evt.bg_halted
                                      && bg_en && !wr_cfg)
                                     |=> stopped_q && state_q == ST_BG_STOPPED)
    else $error("halt not reported as stopped");
  a_resume_clears: assert property ((state_q == ST_BG_STOPPED && cal_trigger && bg_en
                                     && !wr_cfg) |=> !stopped_q ##1 !stopped_q)
    else $error("resume did not clear stopped flag");
  a_bg_off_stopped: assert property ((state_q == ST_FG && engine_evt.fg_finished
                                      && !bg_en && !wr_cfg) |=> stopped_q && foreground_complete_flag_q)
    else $error("foreground end not flagged stopped");
  a_trig_wakes: assert property ((state_q == ST_LP_SLEEP && lp_active && trigger_controlled_sleep
                                  && !cal_trigger && !wr_cfg)
                                 |=> state_q == ST_LP_WAKE ##1 engine_ctl.core_sleep == 1'b0)
    else $error("trigger low did not wake core");
  a_trig_holds_sleep: assert property ((state_q == ST_LP_SLEEP && lp_active && trigger_controlled_sleep
                                        && cal_trigger && !wr_cfg) |=> state_q == ST_LP_SLEEP)
    else $error("core woke while trigger high");
  a_sleep_timed: assert property (enter_sleep && !trigger_controlled_sleep |-> timer_load
                                  && (slp_code == 3'd0 ? timer_cycles == `DLY_CODE0_CYCLES
                                      : timer_cycles - `DLY_TAIL_CYCLES
                                        == 41'd1 << (SLEEP_EXP_BASE + 3 * slp_code)))
    else $error("sleep timer not loaded from code");
  a_wake_timed: assert property (enter_wake |-> timer_load
                                 && (wake_code == 2'd0 ? timer_cycles == `DLY_CODE0_CYCLES
                                     : timer_cycles - `DLY_TAIL_CYCLES
                                       == 41'd1 << (WAKE_EXP_BASE + 3 * wake_code)))
    else $error("wake timer not loaded from code");
  a_status_reserved: assert property ((setup && hit_sts && !apb_req.pwrite)
                                      |=> apb_rsp.prdata[31:5] == 27'h0000000)
    else $error("status reserved bits not zero");
  a_lp_needs_bg: assert property (!bg_en |=> !engine_ctl.core_sleep
                                  && !engine_ctl.bg_run)
    else $error("background activity while disabled");

  c_fg_complete: cover property (state_q == ST_FG ##1 foreground_complete_flag_q);
  c_bg_stopped: cover property (state_q == ST_BG_HALT ##1 state_q == ST_BG_STOPPED);
  c_lp_cycle: cover property (state_q == ST_LP_WAKE ##1 state_q == ST_LP_CAL);
  c_unmapped: cover property (apb_rsp.pslverr);
endmodule : cal_ctrl

// >>> verification/cal_engine_model.sv
`timescale 1ns/100ps
module cal_engine_model (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire cal_ctrl_pkg::engine_ctl_t ctl,
  input  wire logic [3:0]                lag,
  input  wire logic                      alarm_lvl,
  input  wire logic [2:0]                code_lvl,
  input  wire logic                      trig_lvl,
  output logic                           hardware_trigger_pin,
  output cal_ctrl_pkg::engine_evt_t      evt
);
  import cal_ctrl_pkg::*;
  logic [4:0] cnt_q;
  logic       busy;
  logic       fire;
  // One answer per request, after lag cycles, so slow and prompt engines both occur
  // A lag changed mid-request cannot stall the answer
  assign busy = ctl.fg_start | ctl.bg_stop_req | ctl.core_cal_req;
  assign fire = busy && !cnt_q[4] && (cnt_q[3:0] >= lag);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q                <= 5'h00;
      evt                  <= '0;
      hardware_trigger_pin <= 1'b1;
    end else begin
      hardware_trigger_pin <= trig_lvl;
      evt.alarm            <= alarm_lvl;
      evt.stat_code        <= code_lvl;
      evt.fg_finished      <= fire && ctl.fg_start;
      evt.bg_halted        <= fire && ctl.bg_stop_req;
      evt.core_cal_done    <= fire && ctl.core_cal_req;
      if (!busy)
        cnt_q <= 5'h00;
      else if (fire)
        cnt_q <= 5'h10;
      else if (!cnt_q[4])
        cnt_q <= cnt_q + 5'h01;
    end
  end
endmodule : cal_engine_model

// >>> verification/calibration_trigger_status_lowpower_tb_top.sv
`timescale 1ns/100ps
`include "cal_ctrl_defines.svh"
module calibration_trigger_status_lowpower_tb_top;
  import cal_ctrl_pkg::*;
  localparam int          SIM_BASE = 1;
  localparam int          B_RST = 5, B_FG = 4, B_RUN = 3, B_STOP = 2, B_SLEEP = 1, B_CAL = 0;
  localparam logic [11:0] A_CFG  = {`IDX_CAL_CONFIG, 2'b00};
  localparam logic [11:0] A_STAT = {`IDX_CAL_STATUS, 2'b00};
  localparam logic [11:0] A_PIN  = {`IDX_CAL_PIN_CFG, 2'b00};
  localparam logic [11:0] A_SOFT = {`IDX_CALIBRATION_SOFTWARE_TRIGGER, 2'b00};
  localparam logic [11:0] A_LP   = {`IDX_CAL_LOW_POWER, 2'b00};
  localparam logic [11:0] A_BAD  = 12'h1bc;
  logic        pclk, presetn, trig_lvl, alarm_lvl, exp_pin;
  logic        hardware_trigger_pin, status_output_pin;
  logic [2:0]  code_lvl, sc, wc;
  logic [3:0]  lag;
  logic [33:0] note;
  apb_req_t    apb_req;
  apb_rsp_t    apb_rsp;
  engine_evt_t engine_evt;
  engine_ctl_t engine_ctl;
  int          num_errors, total_checks, seed, n;
  logic [33:0] exp_q[$];

  cal_ctrl #(.SLEEP_EXP_BASE(SIM_BASE), .WAKE_EXP_BASE(SIM_BASE)) cal_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .hardware_trigger_pin(hardware_trigger_pin), .status_output_pin(status_output_pin),
    .engine_evt(engine_evt), .engine_ctl(engine_ctl));
  cal_engine_model cal_engine_model_inst (
    .pclk(pclk), .presetn(presetn), .ctl(engine_ctl), .lag(lag), .alarm_lvl(alarm_lvl),
    .code_lvl(code_lvl), .trig_lvl(trig_lvl), .hardware_trigger_pin(hardware_trigger_pin),
    .evt(engine_evt));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task wrap_up;
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Monitor: every completed transfer retires the oldest note
  always @(posedge pclk) begin
    if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check("pslverr", {31'h0, note[32]}, {31'h0, apb_rsp.pslverr});
      if (!note[33])
        check("prdata", note[31:0], apb_rsp.prdata);
    end
  end

  task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic err);
    int k;
    @(posedge pclk);
    exp_q.push_back({w, err, 24'h0, d});
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 20);
    if (k >= 20)
      check("pready", 32'h1, 32'h0);
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr

  task rd(input logic [11:0] a, input logic [7:0] d);
    apb(1'b0, a, d, 1'b0);
  endtask : rd

  task wait_bit(input int idx, input logic v, input int max, input string what);
    int k;
    k = 0;
    while (engine_ctl[idx] !== v && k < max) begin
      @(posedge pclk);
      k++;
    end
    check(what, {31'h0, v}, {31'h0, engine_ctl[idx]});
  endtask : wait_bit

  task hold_bit(input int idx, input logic v, input int cycles, input string what);
    logic bad;
    bad = 1'b0;
    repeat (cycles) begin
      @(posedge pclk);
      if (engine_ctl[idx] !== v)
        bad = 1'b1;
    end
    check(what, 32'h0, {31'h0, bad});
  endtask : hold_bit

  function automatic int dly(input int code);
    return (code == 0) ? 1152 : (1 << (SIM_BASE + 3 * code)) + 128;
  endfunction : dly

  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end

  initial begin
    seed      = 99898;
    apb_req   = '0;
    presetn   = 1'b0;
    trig_lvl  = 1'b1;
    alarm_lvl = 1'($random(seed));
    code_lvl  = 3'($random(seed));
    lag       = 4'($random(seed));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_PIN, 8'h00);
    rd(A_SOFT, 8'h01);
    rd(A_LP, 8'h88);
    wait_bit(B_FG, 1'b0, 100, "fg end");
    repeat (3) @(posedge pclk);
    rd(A_STAT, {3'h0, code_lvl, 2'b11});
    wr(A_STAT, 8'hff);
    rd(A_STAT, {3'h0, code_lvl, 2'b11});
    apb(1'b0, A_BAD, 8'h00, 1'b1);
    apb(1'b1, A_BAD, 8'h5a, 1'b1);
    wr(A_PIN, 8'hf8);
    rd(A_PIN, 8'h00);
    wr(A_CFG, 8'h02);
    wait_bit(B_RUN, 1'b1, 50, "bg run");
    for (int c = 0; c < 5; c++) begin
      alarm_lvl <= (c == 4) ? ~alarm_lvl : 1'($random(seed));
      sc = (c > 3) ? 3'd2 : 3'(c);
      wr(A_PIN, {5'h0, sc[1:0], 1'b0});
      repeat (3) @(posedge pclk);
      exp_pin = (sc == 3'd0) ? 1'b1 : (sc == 3'd2) ? alarm_lvl : 1'b0;
      check("status pin", {31'h0, exp_pin}, {31'h0, status_output_pin});
    end
    wr(A_PIN, 8'h00);
    wr(A_SOFT, 8'h00);
    wait_bit(B_STOP, 1'b1, 10, "stop req");
    wait_bit(B_STOP, 1'b0, 40, "halted");
    repeat (2) @(posedge pclk);
    rd(A_STAT, {3'h0, code_lvl, 2'b11});
    wr(A_SOFT, 8'h01);
    wait_bit(B_RUN, 1'b1, 10, "resume");
    rd(A_STAT, {3'h0, code_lvl, 2'b01});
    wr(A_PIN, 8'h01);
    wr(A_SOFT, 8'h00);
    hold_bit(B_RUN, 1'b1, 20, "soft ignored");
    trig_lvl <= 1'b0;
    wait_bit(B_STOP, 1'b1, 8, "pin stop");
    trig_lvl <= 1'b1;
    wait_bit(B_RUN, 1'b1, 40, "pin resume");
    wr(A_SOFT, 8'h01);
    wr(A_PIN, 8'h00);
    trig_lvl <= 1'b0;
    hold_bit(B_RUN, 1'b1, 20, "pin ignored");
    trig_lvl <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      sc  = (i == 0) ? 3'd0 : 3'd4;
      wc  = (i == 0) ? 3'd1 : 3'd2;
      lag <= 4'($random(seed));
      wr(A_LP, {sc, wc[1:0], 3'b001});
      wait_bit(B_CAL, 1'b1, 20000, "lp cal");
      wait_bit(B_SLEEP, 1'b1, 100, "lp sleep");
      n = 1;
      @(posedge pclk);
      while (engine_ctl[B_SLEEP] === 1'b1 && n < 20000) begin
        n++;
        @(posedge pclk);
      end
      check("sleep cycles", 32'(dly(int'(sc)) + 1), 32'(n));
      n = 0;
      while (engine_ctl[B_CAL] === 1'b0 && n < 5000) begin
        n++;
        @(posedge pclk);
      end
      check("wake cycles", 32'(dly(int'(wc)) + 1), 32'(n));
    end
    wr(A_LP, 8'h0b);
    wait_bit(B_SLEEP, 1'b1, 20000, "trig sleep");
    hold_bit(B_SLEEP, 1'b1, 300, "trig held");
    wr(A_SOFT, 8'h00);
    wait_bit(B_SLEEP, 1'b0, 8, "trig wake");
    wr(A_SOFT, 8'h01);
    wr(A_CFG, 8'h00);
    hold_bit(B_FG, 1'b0, 30, "fg skipped");
    hold_bit(B_SLEEP, 1'b0, 200, "lp needs bg");
    rd(A_STAT, {3'h0, code_lvl, 2'b11});
    wr(A_CFG, 8'h01);
    wait_bit(B_RST, 1'b1, 3, "values reset");
    wait_bit(B_FG, 1'b1, 3, "fg start");
    wrap_up();
  end
endmodule : calibration_trigger_status_lowpower_tb_top
